// ### lp_next_page_pkg.sv
// Purpose: Constants for the link partner next page register block
// Assumes: 32-bit Avalon-MM data, byte addresses, 25 MHz clock
// Notes:   The register occupies one aligned word; data in bits 15:0
package lp_next_page_pkg;
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned DATA_W         = 32;
    localparam int unsigned PAGE_W         = 16;
    localparam int unsigned CODE_W         = 11;
    localparam logic [7:0]  LP_NEXT_PAGE_OFFSET = 8'h08;
    localparam int unsigned NEXT_PAGE_BIT  = 15;
    localparam int unsigned ACK_BIT        = 14;
    localparam int unsigned MSG_PAGE_BIT   = 13;
    localparam int unsigned ACK2_BIT       = 12;
    localparam int unsigned TOGGLE_BIT     = 11;
    localparam int unsigned CODE_MSB       = 10;
    localparam logic [10:0] NULL_PAGE_CODE = 11'h001;
    localparam logic [15:0] PAGE_RESET     = 16'h0001;
    localparam logic        PREV_TOGGLE_RESET = 1'b1;
    localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
endpackage

// ### lp_next_page_reg.sv
// Purpose: Read-only link partner next page register on Avalon-MM
// Assumes: Page strobe and word come from arbitration on clk_i
// Notes:   Every access is answered after one wait cycle
// Operation
// (RULE_01) A read-only 16-bit register at 0x0008 holds the latest partner next page.
// (RULE_02) Bit 15 shows whether the partner wants to send more next pages.
// (RULE_03) Bit 14 shows whether the partner acknowledged our link code word.
// (RULE_04) Bit 13 is 1 for a message page and 0 for an unformatted page.
// (RULE_05) Bit 12 shows whether the partner can comply with the message.
// (RULE_06) Bit 11 is the inverse of the toggle bit of the previous word.
// (RULE_07) Bits 10:0 hold the code field, message code or unformatted data.
// (RULE_08) After reset the flags read 0 and the code reads 1, a Null Page.
// (RULE_09) Software writes change nothing; only a new received page does.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ns
module lp_next_page_reg
    import lp_next_page_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [DATA_W-1:0] avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic              page_valid_i,
    input  wire logic [PAGE_W-1:0] page_word_i,
    output logic                   remote_next_page_o,
    output logic                   remote_ack_o,
    output logic                   remote_msg_page_o,
    output logic                   remote_ack2_o,
    output logic                   remote_toggle_o,
    output logic      [CODE_W-1:0] remote_code_o
);
    typedef struct packed {
        logic              ack;
        logic [DATA_W-1:0] rdata;
    } bus_t;

    bus_t              bus_q;
    bus_t              bus_d;
    logic [PAGE_W-1:0] page;
    logic              req;

    function automatic logic hit(input logic [ADDR_W-1:0] a);
        hit = (a == LP_NEXT_PAGE_OFFSET);
    endfunction

    lp_page_store u_store (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .page_valid_i (page_valid_i),
        .page_word_i  (page_word_i),
        .page_o       (page)
    );

    assign req = avs_read_i | avs_write_i;

    always_comb
    begin
        bus_d       = bus_q;
        bus_d.ack   = req & ~bus_q.ack;
        if (req & ~bus_q.ack & avs_read_i)
        begin
            // Writes fall through: the register has no write path
            if (hit(avs_address_i)) // [RULE_01]
            begin
                bus_d.rdata = {16'h0000, page};
            end
            else
            begin
                bus_d.rdata = UNMAPPED_DATA;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_q.ack   <= 1'b0;
            bus_q.rdata <= UNMAPPED_DATA;
        end
        else
        begin
            bus_q <= bus_d;
        end
    end

    assign avs_waitrequest_o  = req & ~bus_q.ack;
    assign avs_readdata_o     = bus_q.rdata;
    assign remote_next_page_o = page[NEXT_PAGE_BIT]; // [RULE_02]
    assign remote_ack_o       = page[ACK_BIT];       // [RULE_03]
    assign remote_msg_page_o  = page[MSG_PAGE_BIT];  // [RULE_04]
    assign remote_ack2_o      = page[ACK2_BIT];      // [RULE_05]
    assign remote_toggle_o    = page[TOGGLE_BIT];    // [RULE_06]
    assign remote_code_o      = page[CODE_MSB:0];    // [RULE_07]

    // Helper: page as it stood one cycle ago
    logic [PAGE_W-1:0] page_past_q;
    logic              prev_tog_q;
    always_ff @(posedge clk_i)
    begin
        page_past_q <= page;
        if (rst_i)
        begin
            prev_tog_q <= PREV_TOGGLE_RESET;
        end
        else if (page_valid_i)
        begin
            prev_tog_q <= page_word_i[TOGGLE_BIT];
        end
    end

    a_read_data_map: assert property ( // [RULE_01]
        @(posedge clk_i) disable iff (rst_i)
        (avs_read_i && avs_waitrequest_o && hit(avs_address_i)
            && !page_valid_i)
        |=> (!avs_waitrequest_o && avs_readdata_o == {16'h0000, page}))
        else $error("register read returned wrong data");

    a_unmapped_zero: assert property ( // [RULE_01]
        @(posedge clk_i) disable iff (rst_i)
        (avs_read_i && avs_waitrequest_o && !hit(avs_address_i))
        |=> (avs_readdata_o == UNMAPPED_DATA))
        else $error("unmapped read not zero");

    a_wait_one_cycle: assert property ( // [RULE_01]
        @(posedge clk_i) disable iff (rst_i)
        $rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("waitrequest not released after one cycle");

    a_flags_capture: assert property ( // [RULE_02]
        @(posedge clk_i) disable iff (rst_i)
        page_valid_i |=> (page[15:12] == $past(page_word_i[15:12])))
        else $error("flag bits not captured from page");

    a_code_capture: assert property ( // [RULE_07]
        @(posedge clk_i) disable iff (rst_i)
        page_valid_i |=> (remote_code_o == $past(page_word_i[10:0])))
        else $error("code field not captured");

    a_toggle_inverse: assert property ( // [RULE_06]
        @(posedge clk_i) disable iff (rst_i)
        page_valid_i |=> (remote_toggle_o == !$past(prev_tog_q)))
        else $error("toggle not inverse of previous word");

    a_reset_null: assert property ( // [RULE_08]
        @(posedge clk_i)
        $past(rst_i) |-> (page == PAGE_RESET
            && avs_waitrequest_o == req))
        else $error("reset value not a Null Page");

    a_write_no_effect: assert property ( // [RULE_09]
        @(posedge clk_i) disable iff (rst_i)
        (avs_write_i && !page_valid_i) |=> (page == page_past_q))
        else $error("software write altered the register");

    a_hold_no_page: assert property ( // [RULE_09]
        @(posedge clk_i) disable iff (rst_i)
        !page_valid_i [*2] |-> (page == page_past_q))
        else $error("register changed without a new page");

    a_next_page_cap: assert property ( // [RULE_02]
        @(posedge clk_i) disable iff (rst_i)
        page_valid_i
        |=> (remote_next_page_o == $past(page_word_i[NEXT_PAGE_BIT])))
        else $error("next page flag not captured");

    a_ack_cap: assert property ( // [RULE_03]
        @(posedge clk_i) disable iff (rst_i)
        page_valid_i
        |=> (remote_ack_o == $past(page_word_i[ACK_BIT])))
        else $error("acknowledge flag not captured");

    a_msg_page_cap: assert property ( // [RULE_04]
        @(posedge clk_i) disable iff (rst_i)
        page_valid_i
        |=> (remote_msg_page_o == $past(page_word_i[MSG_PAGE_BIT])))
        else $error("message page flag not captured");

    a_ack2_cap: assert property ( // [RULE_05]
        @(posedge clk_i) disable iff (rst_i)
        page_valid_i
        |=> (remote_ack2_o == $past(page_word_i[ACK2_BIT])))
        else $error("second acknowledge flag not captured");

    a_upper_zero: assert property ( // [RULE_01]
        @(posedge clk_i) disable iff (rst_i)
        (avs_read_i && !avs_waitrequest_o)
        |-> (avs_readdata_o[DATA_W-1:PAGE_W] == 16'h0000))
        else $error("upper read data bits not zero");

    a_idle_no_wait: assert property ( // [RULE_01]
        @(posedge clk_i) disable iff (rst_i)
        !req
        |-> !avs_waitrequest_o)
        else $error("waitrequest high with no request");

    // A page arriving with the read is seen by the next read only
    a_read_old_value: assert property ( // [RULE_01]
        @(posedge clk_i) disable iff (rst_i)
        (avs_read_i && avs_waitrequest_o && hit(avs_address_i)
            && page_valid_i)
        |=> (avs_readdata_o == {16'h0000, $past(page)}))
        else $error("read beside new page returned wrong data");

    a_write_keeps_data: assert property ( // [RULE_09]
        @(posedge clk_i) disable iff (rst_i)
        (avs_write_i && avs_waitrequest_o)
        |=> (avs_readdata_o == $past(avs_readdata_o)))
        else $error("write changed the read data");

    c_read_hit: cover property (
        @(posedge clk_i) disable iff (rst_i)
        avs_read_i && !avs_waitrequest_o && hit(avs_address_i));

    c_write_hit: cover property (
        @(posedge clk_i) disable iff (rst_i)
        avs_write_i && !avs_waitrequest_o && hit(avs_address_i));

    c_message_page: cover property (
        @(posedge clk_i) disable iff (rst_i)
        page_valid_i ##1 remote_msg_page_o && remote_next_page_o);

    c_two_pages: cover property (
        @(posedge clk_i) disable iff (rst_i)
        page_valid_i ##[1:8] page_valid_i);

    c_unmapped_read: cover property (
        @(posedge clk_i) disable iff (rst_i)
        avs_read_i && !avs_waitrequest_o && !hit(avs_address_i));
endmodule

// ### lp_page_store.sv
// Purpose: Holds the last next page received from the link partner
// Assumes: Page strobe comes from logic on the same clock
// Notes:   Toggle stored as the inverse of the previous word's toggle
`timescale 1ns/1ns
module lp_page_store
    import lp_next_page_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              page_valid_i,
    input  wire logic [PAGE_W-1:0] page_word_i,
    output logic      [PAGE_W-1:0] page_o
);
    typedef struct packed {
        logic [PAGE_W-1:0] page;
        logic              prev_toggle;
    } store_t;

    store_t state_q;
    store_t state_d;

    always_comb
    begin
        state_d = state_q;
        if (page_valid_i)
        begin
            state_d.page = page_word_i;
            // Opposite of toggle in the previously exchanged word
            state_d.page[TOGGLE_BIT] = ~state_q.prev_toggle; // [RULE_06]
            state_d.prev_toggle      = page_word_i[TOGGLE_BIT];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q.page        <= PAGE_RESET; // [RULE_08]
            state_q.prev_toggle <= PREV_TOGGLE_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign page_o = state_q.page;
endmodule

// ### lp_partner_model.sv
// Purpose: Remote link partner model that delivers received next pages
// Assumes: Each page arrives on clk_i as a one-cycle strobe
// Notes:   Idle word lines show the inverse of the last page sent
`timescale 1ns/1ns
module lp_partner_model
    import lp_next_page_pkg::*;
(
    input  wire logic              clk_i,
    output logic                   page_valid_o,
    output logic      [PAGE_W-1:0] page_word_o
);
    initial
    begin
        page_valid_o = 1'b0;
        page_word_o  = 16'h5a5a;
    end

    task automatic send(input logic [PAGE_W-1:0] w);
    begin
        @(posedge clk_i);
        page_valid_o <= 1'b1;
        page_word_o  <= w;
        @(posedge clk_i);
        page_valid_o <= 1'b0;
        // Stale word must not look like a valid page
        page_word_o  <= ~w;
    end
    endtask
endmodule

// ### testbench.sv
// Purpose: Self-checking bench for the partner next page register
// Assumes: Avalon-MM master waits for waitrequest low
// Notes:   Expected pages are rebuilt from the received words
`timescale 1ns/1ns
module testbench
    import lp_next_page_pkg::*;
;
    logic              clk_i;
    logic              rst_i;
    logic [ADDR_W-1:0] avs_address_i;
    logic              avs_read_i;
    logic              avs_write_i;
    logic [DATA_W-1:0] avs_writedata_i;
    logic [DATA_W-1:0] avs_readdata_o;
    logic              avs_waitrequest_o;
    logic              page_valid_i;
    logic [PAGE_W-1:0] page_word_i;
    logic              np_o, ack_o, mp_o, ack2_o, tog_o;
    logic [CODE_W-1:0] code_o;
    logic [PAGE_W-1:0] outs;
    logic [DATA_W-1:0] rd;
    logic [PAGE_W-1:0] pages [4];
    logic [PAGE_W-1:0] exp_page;
    logic              prev_tog;
    int                err_count;
    int                cmp_count;

    lp_next_page_reg uut (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .page_valid_i(page_valid_i), .page_word_i(page_word_i),
        .remote_next_page_o(np_o), .remote_ack_o(ack_o),
        .remote_msg_page_o(mp_o), .remote_ack2_o(ack2_o),
        .remote_toggle_o(tog_o), .remote_code_o(code_o));

    lp_partner_model lp (.clk_i(clk_i), .page_valid_o(page_valid_i),
        .page_word_o(page_word_i));

    assign outs = {np_o, ack_o, mp_o, ack2_o, tog_o, code_o};

    task automatic give_verdict;
    begin
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] d);
        int n;
    begin
        n = 0;
        @(posedge clk_i);
        avs_read_i      <= ~wr;
        avs_write_i     <= wr;
        avs_address_i   <= a;
        avs_writedata_i <= wd;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (n == 20)
            err_count++;
        d = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    end
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial
    begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        give_verdict();
    end

    initial
    begin
        rst_i = 1'b1;
        avs_address_i = 8'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0000_0000;
        pages = '{16'hf800, 16'h07ff, 16'ha555, 16'h5aaa};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 8'h08, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0001);
        chk({16'h0000, outs}, 32'h0000_0001);
        prev_tog = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            lp.send(pages[i]);
            exp_page = {pages[i][15:12], ~prev_tog, pages[i][10:0]};
            prev_tog = pages[i][11];
            bus(1'b0, 8'h08, 32'h0000_0000, rd);
            chk(rd, {16'h0000, exp_page});
            chk({16'h0000, outs}, {16'h0000, exp_page});
        end
        bus(1'b1, 8'h08, 32'hffff_ffff, rd);
        bus(1'b0, 8'h08, 32'h0000_0000, rd);
        chk(rd, {16'h0000, exp_page});
        bus(1'b0, 8'h0c, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 8'h08, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0001);
        lp.send(16'h3c05);
        @(posedge clk_i);
        chk({16'h0000, outs}, 32'h0000_3405);
        give_verdict();
    end
endmodule
